// ### core/arat_core.sv
// Converter result registers, auto-trigger control and input disables on AHB-Lite
`timescale 1ns/1ps

// Summary of operation
// R1 - Finished conversion result lands in result bytes
// R2 - Differential channel result becomes two's complement
// R3 - Low byte read locks result until high read
// R4 - Software reads low byte first, except 8-bit left
// R5 - Left adjust selects result byte packing
// R6 - Reserved control_b bits written zero, read zero
// R7 - Trigger source used only with auto-trigger on
// R8 - Auto start on rising edge of flag
// R9 - Switch to set source counts as edge
// R10 - Switching to free running never triggers
// R11 - Trigger source code table, three bits
// R12 - No free running on differential channels; free running here restarts on any channel
// R13 - Disable bits switch off pin input buffers
// R14 - Disabled pins read zero in readback
// R15 - Disable unused digital inputs on analog pins
// R16 - Done flag set when result updated
// R17 - Done flag cleared by one or vector
// R18 - Auto-trigger enable bit starts from source
// R19 - Enable bit off aborts running conversion
// R20 - Edge found by comparing registered selected level
module arat_core
  import arat_pkg::*;
#(
  parameter int PIN_COUNT = 16,
  parameter int RESULT_WIDTH = 10
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic [6:0] trigger_flags,
  input wire logic [RESULT_WIDTH-1:0] conv_result_in,
  input wire logic conv_finish,
  output logic conv_start,
  output logic conv_abort,
  output logic converter_on,
  output logic conv_done_flag,
  input wire logic vector_ack,
  input wire logic [PIN_COUNT-1:0] pin_levels,
  output logic [PIN_COUNT-1:0] digital_input_off
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  arat_trig_if trig ();  // Link to the edge detector

  logic wr_pend_reg;  // Write data phase pending
  logic wr_pend_next;
  logic rd_wait_reg;  // Read wait state
  logic rd_wait_next;
  logic [7:0] idx_reg;  // Index captured in address phase
  logic [7:0] idx_next;
  logic [31:0] hrdata_reg;  // Read data
  logic [31:0] hrdata_next;
  logic enable_reg;  // converter_enable
  logic enable_next;
  logic auto_reg;  // auto_trigger_enable
  logic auto_next;
  logic done_reg;  // conversion_done_flag
  logic done_next;
  logic busy_reg;  // Conversion running
  logic busy_next;
  logic sw_start_reg;  // Software start waiting to be issued
  logic sw_start_next;
  logic fin_d_reg;  // Conversion ended last cycle, free-running restart
  logic fin_d_next;
  logic start_reg;  // Start pulse to the converter
  logic start_next;
  logic abort_reg;  // Abort pulse to the converter
  logic abort_next;
  logic lock_reg;  // Result frozen after low byte read
  logic lock_next;
  logic [RESULT_WIDTH-1:0] result_reg;  // Latest accepted result
  logic [RESULT_WIDTH-1:0] result_next;
  logic [7:0] ctrl_b_reg;  // control_status_b
  logic [7:0] ctrl_b_next;
  logic [7:0] chan_sel_reg;  // channel_select_register
  logic [7:0] chan_sel_next;
  logic [7:0] dis_low_reg;  // input_disable_low
  logic [7:0] dis_low_next;
  logic [7:0] dis_high_reg;  // input_disable_high
  logic [7:0] dis_high_next;

  logic addr_take;  // Valid address phase this cycle
  logic [7:0] wbyte;  // Written byte
  logic [7:0] low_byte;  // Packed low result byte
  logic [7:0] high_byte;  // Packed high result byte
  logic [7:0] ctrl_a_view;  // control_status_a as read
  logic diff_chan;  // Differential channel selected
  logic finish_ok;  // Finish of a running conversion
  logic start_req;  // Some start source asks for a conversion
  logic [PIN_COUNT-1:0] dis_all;  // Both disable registers

  // ----------------------------------------------------------------
  // Trigger edge detector
  // ----------------------------------------------------------------
  // Code 0 holds a constant low level, so choosing free running only
  // ever makes a falling edge and never a trigger
  assign trig.source_sel = ctrl_b_reg[2:0];  // see R11
  assign trig.flag_levels = {trigger_flags, 1'b0};  // see R10

  arat_trig_edge u_edge (
    .hclk(hclk),
    .hresetn(hresetn),
    .trig(trig)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Differential codes span the gain and pair rows; bandgap and ground
  // rows at the top of each half stay single ended
  function automatic logic is_diff(input logic [4:0] code);
    is_diff = (code >= ARAT_CHAN_DIFF_FIRST) && (code <= ARAT_CHAN_DIFF_LAST);
  endfunction

  // Converter delivers offset binary; flipping the top bit gives
  // two's complement for signed differential readings
  function automatic logic [RESULT_WIDTH-1:0] encode(input logic [RESULT_WIDTH-1:0] raw,
                                                      input logic signed_mode);
    encode = raw;
    if (signed_mode) begin
      encode[RESULT_WIDTH-1] = ~raw[RESULT_WIDTH-1];  // see R2
    end
  endfunction

  // ----------------------------------------------------------------
  // Views and pins
  // ----------------------------------------------------------------
  always_comb begin
    addr_take = hsel & hready & (htrans == ARAT_HTRANS_NONSEQ);
    wbyte = hwdata[7:0];
    diff_chan = is_diff(chan_sel_reg[4:0]);
    finish_ok = conv_finish & busy_reg;
    dis_all = {dis_high_reg, dis_low_reg};  // see R13
    // Packing follows the adjust bit at read time
    if (chan_sel_reg[ARAT_SEL_LEFT_ADJ_BIT]) begin
      high_byte = result_reg[9:2];  // see R5
      low_byte = {result_reg[1:0], 6'h00};
    end else begin
      high_byte = {6'h00, result_reg[9:8]};
      low_byte = result_reg[7:0];
    end
    ctrl_a_view = 8'h00;
    ctrl_a_view[ARAT_A_ENABLE_BIT] = enable_reg;
    ctrl_a_view[ARAT_A_START_BIT] = busy_reg | sw_start_reg;
    ctrl_a_view[ARAT_A_AUTO_BIT] = auto_reg;
    ctrl_a_view[ARAT_A_DONE_BIT] = done_reg;
  end

  // ----------------------------------------------------------------
  // Bus state and registers, next values
  // ----------------------------------------------------------------
  always_comb begin
    wr_pend_next = 1'b0;
    rd_wait_next = 1'b0;
    idx_next = idx_reg;
    hrdata_next = hrdata_reg;
    enable_next = enable_reg;
    auto_next = auto_reg;
    done_next = done_reg;
    sw_start_next = sw_start_reg;
    lock_next = lock_reg;
    ctrl_b_next = ctrl_b_reg;
    chan_sel_next = chan_sel_reg;
    dis_low_next = dis_low_reg;
    dis_high_next = dis_high_reg;

    // Address phase, only while no wait state is running
    if (addr_take && !rd_wait_reg) begin
      idx_next = haddr[9:2];
      wr_pend_next = hwrite;
      rd_wait_next = ~hwrite;
    end

    // Read data formed one cycle late so a write just before lands first
    if (rd_wait_reg) begin
      hrdata_next = 32'h0000_0000;
      unique case (idx_reg)
        ARAT_IDX_RESULT_LOW: begin
          hrdata_next[7:0] = low_byte;
          lock_next = 1'b1;  // see R3
        end
        ARAT_IDX_RESULT_HIGH: begin
          hrdata_next[7:0] = high_byte;
          lock_next = 1'b0;  // see R3
        end
        ARAT_IDX_CONTROL_A: hrdata_next[7:0] = ctrl_a_view;
        ARAT_IDX_CONTROL_B: hrdata_next[7:0] = ctrl_b_reg;
        ARAT_IDX_CHANNEL_SEL: hrdata_next[7:0] = chan_sel_reg;
        ARAT_IDX_DISABLE_HIGH: hrdata_next[7:0] = dis_high_reg;
        ARAT_IDX_DISABLE_LOW: hrdata_next[7:0] = dis_low_reg;
        ARAT_IDX_PORT_READBACK: hrdata_next[PIN_COUNT-1:0] = pin_levels & ~dis_all; // see R14
        default: hrdata_next = 32'h0000_0000;  // Unmapped reads zero
      endcase
    end

    // Write data phase; unmapped and read-only indexes are ignored
    if (wr_pend_reg) begin
      unique case (idx_reg)
        ARAT_IDX_CONTROL_A: begin
          enable_next = wbyte[ARAT_A_ENABLE_BIT];  // see R19
          auto_next = wbyte[ARAT_A_AUTO_BIT];  // see R18
          if (wbyte[ARAT_A_START_BIT]) begin
            sw_start_next = 1'b1;
          end
          if (wbyte[ARAT_A_DONE_BIT]) begin
            done_next = 1'b0;  // see R17
          end
        end
        ARAT_IDX_CONTROL_B: ctrl_b_next = wbyte & ARAT_B_WRITE_MASK;  // see R6
        ARAT_IDX_CHANNEL_SEL: chan_sel_next = wbyte & ARAT_SEL_WRITE_MASK;
        ARAT_IDX_DISABLE_HIGH: dis_high_next = wbyte;  // see R13
        ARAT_IDX_DISABLE_LOW: dis_low_next = wbyte;  // see R13
        default: ;
      endcase
    end

    // Vector acknowledge clears too; a finishing conversion beats both
    if (vector_ack) begin
      done_next = 1'b0;  // see R17
    end
    if (finish_ok) begin
      done_next = 1'b1;  // see R16
    end
    // Turning off drops any start still waiting
    if (!enable_next || start_reg) begin
      sw_start_next = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Conversion control, next values
  // ----------------------------------------------------------------
  // Triggers that arrive while a conversion runs are dropped, as the
  // converter can hold only one conversion at a time
  always_comb begin
    start_req = sw_start_reg;
    if (auto_reg) begin
      start_req = start_req | trig.trig_pulse;  // see R7, R8, R9
      if (ctrl_b_reg[2:0] == ARAT_SRC_FREE_RUN) begin
        start_req = start_req | fin_d_reg;
      end
    end
    start_next = enable_reg & ~busy_reg & ~start_reg & start_req;
    abort_next = busy_reg & ~enable_reg;  // see R19
    busy_next = busy_reg;
    if (start_reg) begin
      busy_next = 1'b1;
    end
    if (finish_ok || !enable_reg) begin
      busy_next = 1'b0;  // see R19
    end
    fin_d_next = finish_ok;
    result_next = result_reg;
    // A locked pair keeps its value; the new result is lost
    if (finish_ok && !lock_reg) begin
      result_next = encode(conv_result_in, diff_chan);  // see R1, R2
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      rd_wait_reg <= 1'b0;
      idx_reg <= ARAT_RESET_BYTE;
      hrdata_reg <= 32'h0000_0000;
      enable_reg <= 1'b0;
      auto_reg <= 1'b0;
      done_reg <= 1'b0;
      busy_reg <= 1'b0;
      sw_start_reg <= 1'b0;
      fin_d_reg <= 1'b0;
      start_reg <= 1'b0;
      abort_reg <= 1'b0;
      lock_reg <= 1'b0;
      result_reg <= ARAT_RESET_RESULT;
      ctrl_b_reg <= ARAT_RESET_BYTE;
      chan_sel_reg <= ARAT_RESET_BYTE;
      dis_low_reg <= ARAT_RESET_BYTE;
      dis_high_reg <= ARAT_RESET_BYTE;
    end else begin
      wr_pend_reg <= wr_pend_next;
      rd_wait_reg <= rd_wait_next;
      idx_reg <= idx_next;
      hrdata_reg <= hrdata_next;
      enable_reg <= enable_next;
      auto_reg <= auto_next;
      done_reg <= done_next;
      busy_reg <= busy_next;
      sw_start_reg <= sw_start_next;
      fin_d_reg <= fin_d_next;
      start_reg <= start_next;
      abort_reg <= abort_next;
      lock_reg <= lock_next;
      result_reg <= result_next;
      ctrl_b_reg <= ctrl_b_next;
      chan_sel_reg <= chan_sel_next;
      dis_low_reg <= dis_low_next;
      dis_high_reg <= dis_high_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Stall only during the read wait state
  assign hreadyout = ~rd_wait_reg;
  assign hrdata = hrdata_reg;
  assign hresp = 1'b0;
  assign conv_start = start_reg;
  assign conv_abort = abort_reg;
  assign converter_on = enable_reg;
  assign conv_done_flag = done_reg;
  assign digital_input_off = dis_all;  // see R13

endmodule // arat_core

// ### common/arat_pkg.sv
// Constants shared by the converter result and auto-trigger block
package arat_pkg;

  // ----------------------------------------------------------------
  // Register indexes; byte address on the bus is four times the index
  // ----------------------------------------------------------------
  localparam logic [7:0] ARAT_IDX_RESULT_LOW = 8'h78;
  localparam logic [7:0] ARAT_IDX_RESULT_HIGH = 8'h79;
  localparam logic [7:0] ARAT_IDX_CONTROL_A = 8'h7A;
  localparam logic [7:0] ARAT_IDX_CONTROL_B = 8'h7B;
  localparam logic [7:0] ARAT_IDX_CHANNEL_SEL = 8'h7C;
  localparam logic [7:0] ARAT_IDX_DISABLE_HIGH = 8'h7D;
  localparam logic [7:0] ARAT_IDX_DISABLE_LOW = 8'h7E;
  localparam logic [7:0] ARAT_IDX_PORT_READBACK = 8'h80;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int ARAT_A_ENABLE_BIT = 7;
  localparam int ARAT_A_START_BIT = 6;
  localparam int ARAT_A_AUTO_BIT = 5;
  localparam int ARAT_A_DONE_BIT = 4;
  localparam int ARAT_B_CMP_MUX_BIT = 6;
  localparam int ARAT_B_CHAN_MSB_BIT = 3;
  localparam int ARAT_SEL_LEFT_ADJ_BIT = 5;
  localparam logic [7:0] ARAT_B_WRITE_MASK = 8'h4F;
  localparam logic [7:0] ARAT_SEL_WRITE_MASK = 8'h3F;

  // ----------------------------------------------------------------
  // Reset values and codes
  // ----------------------------------------------------------------
  localparam logic [7:0] ARAT_RESET_BYTE = 8'h00;
  localparam logic [9:0] ARAT_RESET_RESULT = 10'h000;
  localparam logic [2:0] ARAT_SRC_FREE_RUN = 3'h0;
  localparam logic [4:0] ARAT_CHAN_DIFF_FIRST = 5'h08;
  localparam logic [4:0] ARAT_CHAN_DIFF_LAST = 5'h1D;
  localparam logic [1:0] ARAT_HTRANS_NONSEQ = 2'h2;

endpackage : arat_pkg

// ### common/arat_trig_if.sv
// Trigger selection and edge signals between the core and its edge detector
`timescale 1ns/1ps
interface arat_trig_if;
  logic [2:0] source_sel;  // Selected trigger source code
  logic [7:0] flag_levels;  // Flag level per source code, code 0 held low
  logic trig_pulse;  // One-cycle rising edge of the selected level

  modport core (output source_sel, output flag_levels, input trig_pulse);
  modport det (input source_sel, input flag_levels, output trig_pulse);
endinterface : arat_trig_if

// ### core/arat_trig_edge.sv
// Rising edge detector on the selected auto-trigger flag level
`timescale 1ns/1ps
module arat_trig_edge
  import arat_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  arat_trig_if.det trig
);

  logic level_prev_reg;  // Selected level seen last cycle
  logic level_prev_next;
  logic pulse_reg;  // Registered edge pulse
  logic pulse_next;
  logic sel_level;  // Level of the currently chosen source

  // ----------------------------------------------------------------
  // Edge compare
  // ----------------------------------------------------------------
  // Sampling the muxed level, not each flag, so a source switch from a
  // low flag to a high one looks exactly like a flag edge
  always_comb begin
    sel_level = trig.flag_levels[trig.source_sel];
    level_prev_next = sel_level;  // see R20
    pulse_next = sel_level & ~level_prev_reg;  // see R8, R9
  end

  // Registers only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      level_prev_reg <= 1'b0;
      pulse_reg <= 1'b0;
    end else begin
      level_prev_reg <= level_prev_next;
      pulse_reg <= pulse_next;
    end
  end

  assign trig.trig_pulse = pulse_reg;

endmodule // arat_trig_edge

// ### tb/arat_core_checker.sv
// Port-level assertions for the converter result and auto-trigger block
`timescale 1ns/1ps
module arat_core_checker
  import arat_pkg::*;
#(
  parameter int PIN_COUNT = 16,
  parameter int RESULT_WIDTH = 10
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic conv_finish,
  input wire logic conv_start,
  input wire logic conv_abort,
  input wire logic converter_on,
  input wire logic conv_done_flag,
  input wire logic vector_ack,
  input wire logic [PIN_COUNT-1:0] digital_input_off
);
  // ----------------------------------------------------------------
  // Helper state
  // ----------------------------------------------------------------
  logic take; // Transfer accepted this cycle
  logic busy_reg; // Conversion running, as seen at the ports
  logic busy_next;
  logic wph_reg; // Write data phase in progress
  logic wph_next;
  assign take = hsel && hready && (htrans == ARAT_HTRANS_NONSEQ);
  // Abort clears busy too, so a dropped enable never looks like a hang
  always_comb begin
    busy_next = conv_start ? 1'b1 : ((conv_finish || conv_abort) ? 1'b0 : busy_reg);
    wph_next = (take && hwrite) ? 1'b1 : (hready ? 1'b0 : wph_reg);
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy_reg <= 1'b0;
      wph_reg <= 1'b0;
    end else begin
      busy_reg <= busy_next;
      wph_reg <= wph_next;
    end
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_resp_okay; hresp == 1'b0; endproperty
  a_resp_okay: assert property (p_resp_okay)
    else $error("response not okay");
  property p_read_wait; take && !hwrite |=> !hreadyout ##1 hreadyout; endproperty
  a_read_wait: assert property (p_read_wait)
    else $error("read wait state wrong");
  property p_start_pulse; conv_start |=> !conv_start; endproperty
  a_start_pulse: assert property (p_start_pulse)
    else $error("start longer than one cycle");
  property p_start_idle; busy_reg |-> !conv_start; endproperty
  a_start_idle: assert property (p_start_idle)
    else $error("start while busy");
  property p_start_enabled; conv_start |-> converter_on; endproperty
  a_start_enabled: assert property (p_start_enabled)
    else $error("start while disabled");
  property p_done_set; conv_finish && busy_reg |=> conv_done_flag; endproperty
  a_done_set: assert property (p_done_set)
    else $error("done flag not set");
  property p_done_clear;
    vector_ack && conv_done_flag && !(conv_finish && busy_reg) |=> !conv_done_flag;
  endproperty
  a_done_clear: assert property (p_done_clear)
    else $error("done flag not cleared");
  property p_off_stable; !wph_reg |=> $stable(digital_input_off); endproperty
  a_off_stable: assert property (p_off_stable)
    else $error("input disables changed without write");
  c_start: cover property (conv_start);
  c_abort: cover property (conv_abort);
  c_done: cover property ($rose(conv_done_flag));
endmodule // arat_core_checker

// ### tb/testbench.sv
// Self-checking bench for the converter result and auto-trigger block
`timescale 1ns/1ps
module testbench;
  import arat_pkg::*;
  // ----------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hready, hreadyout, hresp, conv_start, conv_abort, converter_on, conv_done_flag;
  logic [31:0] hrdata;
  logic [6:0] trigger_flags = 7'h00;
  logic [9:0] conv_result_in = 10'h000;
  logic conv_finish = 1'b0;
  logic vector_ack = 1'b0;
  logic [15:0] pin_levels = 16'hFFFF; // All pins high, so readback shows the masking
  logic [15:0] digital_input_off;
  int mismatches = 0;
  int n_compared = 0;
  int cycles = 0;
  int n_start = 0; // Start pulses seen
  int n_abort = 0; // Abort pulses seen
  int k;
  int i;
  logic [31:0] rd;
  assign hready = hreadyout; // Single slave drives the bus ready
  arat_core uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hreadyout, .hrdata, .hresp, .trigger_flags, .conv_result_in, .conv_finish,
    .conv_start, .conv_abort, .converter_on, .conv_done_flag, .vector_ack, .pin_levels,
    .digital_input_off);
  initial forever #25 hclk = ~hclk;
  // Pulses are one cycle wide; counting at the falling edge sees each exactly once
  always @(negedge hclk) begin
    n_start += (conv_start === 1'b1);
    n_abort += (conv_abort === 1'b1);
  end
  // Hang guard, well above the length of the sequence
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      end_of_test();
    end
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Ready is sampled settled, just before the edge that acts on it
  task automatic wait_rdy();
    logic r;
    do begin
      @(negedge hclk);
      r = hreadyout;
      rd = hrdata;
      @(posedge hclk);
    end while (r !== 1'b1);
  endtask
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'h0};
    htrans <= ARAT_HTRANS_NONSEQ;
    hwrite <= w;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    wait_rdy();
  endtask
  task automatic rd_chk(input string what, input logic [7:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 8'h00);
    check(what, exp, rd);
  endtask
  // Start count over a fixed window that covers the two-cycle start latency
  task automatic starts(input string what, input int exp);
    k = n_start;
    repeat (6) @(posedge hclk);
    check(what, exp, n_start - k);
  endtask
  task automatic finish(input logic [9:0] r);
    conv_result_in <= r;
    conv_finish <= 1'b1;
    @(posedge hclk);
    conv_finish <= 1'b0;
    @(posedge hclk);
  endtask
  // Enable, start, clear done; then complete with the given raw result
  task automatic convert(input logic [9:0] r);
    bus(1'b1, ARAT_IDX_CONTROL_A, 8'hD0);
    starts("sw start", 1);
    finish(r);
  endtask
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd_chk("result_low", ARAT_IDX_RESULT_LOW, 32'h0);
    rd_chk("result_high", ARAT_IDX_RESULT_HIGH, 32'h0);
    rd_chk("control_b", ARAT_IDX_CONTROL_B, 32'h0);
    rd_chk("disable_high", ARAT_IDX_DISABLE_HIGH, 32'h0);
    rd_chk("disable_low", ARAT_IDX_DISABLE_LOW, 32'h0);
    // Reserved bits, read-only and unmapped places
    bus(1'b1, ARAT_IDX_CONTROL_B, 8'h38);
    rd_chk("control_b", ARAT_IDX_CONTROL_B, 32'h08);
    bus(1'b1, ARAT_IDX_RESULT_LOW, 8'hFF);
    rd_chk("result_low", ARAT_IDX_RESULT_LOW, 32'h0);
    // The low read froze the pair; the high read lets the next result in
    rd_chk("high unlock", ARAT_IDX_RESULT_HIGH, 32'h0);
    bus(1'b1, 8'h7F, 8'hFF);
    rd_chk("unmapped", 8'h7F, 32'h0);
    bus(1'b1, ARAT_IDX_DISABLE_LOW, 8'hA5);
    bus(1'b1, ARAT_IDX_DISABLE_HIGH, 8'h3C);
    // The write lands at the edge the task ends on; look one edge later
    @(posedge hclk);
    check("input_off", 32'h3CA5, {16'h0, digital_input_off});
    rd_chk("readback", ARAT_IDX_PORT_READBACK, 32'hC35A);
    // Result packing, right then left adjusted, then differential
    convert(10'h2B7);
    check("done", 32'h1, {31'h0, conv_done_flag});
    rd_chk("low right", ARAT_IDX_RESULT_LOW, 32'hB7);
    rd_chk("high right", ARAT_IDX_RESULT_HIGH, 32'h02);
    bus(1'b1, ARAT_IDX_CHANNEL_SEL, 8'h20);
    convert(10'h2B7);
    rd_chk("low left", ARAT_IDX_RESULT_LOW, 32'hC0);
    rd_chk("high left", ARAT_IDX_RESULT_HIGH, 32'hAD);
    bus(1'b1, ARAT_IDX_CHANNEL_SEL, 8'h08);
    convert(10'h2B7);
    rd_chk("low diff", ARAT_IDX_RESULT_LOW, 32'hB7);
    rd_chk("high diff", ARAT_IDX_RESULT_HIGH, 32'h00);
    // Done flag clears by write of one, then by vector acknowledge
    bus(1'b1, ARAT_IDX_CONTROL_A, 8'h90);
    @(posedge hclk);
    check("done wr1", 32'h0, {31'h0, conv_done_flag});
    bus(1'b1, ARAT_IDX_CHANNEL_SEL, 8'h00);
    convert(10'h155);
    vector_ack <= 1'b1;
    @(posedge hclk);
    vector_ack <= 1'b0;
    @(posedge hclk);
    check("done ack", 32'h0, {31'h0, conv_done_flag});
    // Low read locks the pair until the high byte is read
    rd_chk("low lock", ARAT_IDX_RESULT_LOW, 32'h55);
    convert(10'h0AA);
    rd_chk("high lock", ARAT_IDX_RESULT_HIGH, 32'h01);
    rd_chk("low kept", ARAT_IDX_RESULT_LOW, 32'h55);
    // Source selection ignored while auto-trigger is off
    bus(1'b1, ARAT_IDX_CONTROL_B, 8'h01);
    bus(1'b1, ARAT_IDX_CONTROL_A, 8'h80);
    trigger_flags <= 7'h01;
    starts("auto off", 0);
    trigger_flags <= 7'h00;
    bus(1'b1, ARAT_IDX_CONTROL_A, 8'hA0);
    // Source codes 1 to 7: next code's flag ignored, own edge starts once, level does not
    for (i = 1; i <= 7; i++) begin
      bus(1'b1, ARAT_IDX_CONTROL_B, 8'(i));
      trigger_flags <= 7'(1 << (i % 7));
      starts("other src", 0);
      trigger_flags <= 7'(1 << (i % 7)) | 7'(1 << (i - 1));
      starts("own edge", 1);
      finish(10'h001);
      starts("held level", 0);
      trigger_flags <= 7'h00;
    end
    // Switch onto a source whose flag is already set
    trigger_flags <= 7'h02;
    bus(1'b1, ARAT_IDX_CONTROL_B, 8'h02);
    starts("switch edge", 1);
    finish(10'h002);
    // Level low first, so only a high code 0 level could fake an edge here
    trigger_flags <= 7'h00;
    bus(1'b1, ARAT_IDX_CONTROL_B, 8'h00);
    starts("to free run", 0);
    // Free running: software starts the first, each finish restarts
    bus(1'b1, ARAT_IDX_CONTROL_A, 8'hE0);
    starts("free first", 1);
    finish(10'h003);
    starts("free again", 1);
    // Auto off with a start queued; it goes out once the running one ends
    bus(1'b1, ARAT_IDX_CONTROL_A, 8'hC0);
    finish(10'h004);
    starts("abort start", 1);
    k = n_abort;
    bus(1'b1, ARAT_IDX_CONTROL_A, 8'h00);
    repeat (3) @(posedge hclk);
    check("abort", 32'h1, n_abort - k);
    check("converter_on", 32'h0, {31'h0, converter_on});
    end_of_test();
  end
endmodule // testbench
bind arat_core arat_core_checker #(.PIN_COUNT(PIN_COUNT), .RESULT_WIDTH(RESULT_WIDTH)) chk (
  .hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .hreadyout, .hresp, .conv_finish,
  .conv_start, .conv_abort, .converter_on, .conv_done_flag, .vector_ack, .digital_input_off);
